// *** logic/charger_status_pkg.sv ***
// Constants for the charger status signalling block.
// Assumes a 100 MHz system clock; step and tick lengths become cycle counts here.
package charger_status_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int CARRIER_HZ = 35_000;
    // Sixteen sub-steps per carrier period
    localparam int STEPS = 16;
    localparam int STEP_CYC = CLK_HZ / (CARRIER_HZ * STEPS);
    // Blink rates in millihertz; half periods in carrier periods
    localparam int TEMP_BLINK_MHZ = 1500;
    localparam int BAD_BLINK_MHZ = 6100;
    localparam int TEMP_HALF = (CARRIER_HZ * 1000) / (2 * TEMP_BLINK_MHZ);
    localparam int BAD_HALF = (CARRIER_HZ * 1000) / (2 * BAD_BLINK_MHZ);
    // Duty in sixteenths: 1/15 and 2/14
    localparam logic [4:0] TEMP_LO = 5'h01;
    localparam logic [4:0] TEMP_HI = 5'h0F;
    localparam logic [4:0] BAD_LO = 5'h02;
    localparam logic [4:0] BAD_HI = 5'h0E;
    // Timeouts in seconds, counted by a 1 s tick
    localparam int TICK_CYC = CLK_HZ;
    localparam int TRICKLE_TIMEOUT_S = 1800;
    localparam int SAFETY_TIMEOUT_S = 14400;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CHARGE = 4'h2,
        ST_DONE = 4'h4,
        ST_BAD = 4'h8
    } chg_state_t;
endpackage : charger_status_pkg

// *** logic/charger_status_signalling.sv ***
// Charger state, temperature pause and open-drain status output encoder.
// Assumes analog comparator flags arrive asynchronously from the pins.
`timescale 1ns/10ps
// What this block does
// - The status output encodes charging, idle, bad battery and temp fault.
// - The status pin is open drain, driving only low or released.
// - Low while charging, released when idle, 35 kHz carrier on faults.
// - Starting a charge cycle pulls the status pin low for the cycle.
// - Float reached with current under a tenth releases the pin.
// - The tenth-current flag is ignored while input is in current limit.
// - Temp fault duty alternates 1/16 and 15/16, each half of 1.5 Hz.
// - Bad battery duty alternates 2/16 and 14/16, each half of 6.1 Hz, or of 1.5 Hz during a temp fault.
// - Battery under trickle level for half an hour means bad battery.
// - Charging pauses while the thermistor reads hot or cold.
// - In float mode a temperature fault freezes the safety timer.
// - A grounded thermistor input disables temperature pausing.
// - Float starts a four hour timer; expiry stops charge current.
module charger_status_signalling #(
    parameter int TICK_CYC = charger_status_pkg::TICK_CYC
) (
    input wire logic clk_sys, // 100 MHz clock
    input wire logic resetn, // Async reset, active low
    input wire logic charge_start_in, // Charge cycle start request
    input wire logic below_trickle_in, // Battery below trickle level
    input wire logic at_float_in, // Battery at float voltage
    input wire logic tenth_current_in, // Current below a tenth
    input wire logic input_limit_in, // Input supply in current limit
    input wire logic thermistor_hot_in, // Hot comparator
    input wire logic thermistor_cold_in, // Cold comparator
    input wire logic thermistor_grounded_in, // Sense pin tied low
    input wire logic charge_status_out_i, // Status pin level
    output logic charge_status_out_o, // Status pin drive value
    output logic charge_status_out_oe, // High while pulling low
    output logic charge_enable, // Charge current allowed
    output logic temp_fault // Temperature fault shown
);
    localparam int SYNC_W = 7;
    logic [SYNC_W-1:0] raw, s1_r, s2_r;
    assign raw = {charge_start_in, below_trickle_in, at_float_in,
                  tenth_current_in, input_limit_in,
                  thermistor_hot_in | thermistor_cold_in,
                  thermistor_grounded_in};
    wire logic start_s = s2_r[6];
    wire logic low_s = s2_r[5];
    wire logic float_s = s2_r[4];
    wire logic tenth_s = s2_r[3];
    wire logic limit_s = s2_r[2];
    wire logic hotcold_s = s2_r[1];
    wire logic gnd_s = s2_r[0];

    // Two stage synchronisers for every analog flag
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
        end
    end

    charger_status_pkg::chg_state_t st_r, st_nxt;
    logic [7:0] step_cnt_r, step_cnt_nxt;
    logic [3:0] phase_r, phase_nxt;
    logic [13:0] half_cnt_r, half_cnt_nxt;
    logic blink_hi_r, blink_hi_nxt;
    logic [26:0] tick_cnt_r, tick_cnt_nxt;
    logic [13:0] low_sec_r, low_sec_nxt;
    logic [13:0] safe_sec_r, safe_sec_nxt;
    logic safe_run_r, safe_run_nxt;
    logic pull_r, pull_nxt;
    logic en_r, en_nxt;
    logic tf_r, tf_nxt;
    logic step_p, carrier_p, tick_p, tfault;
    logic [4:0] duty;

    always_comb begin
        step_p = (step_cnt_r ==
                  8'(charger_status_pkg::STEP_CYC - 1));
        carrier_p = step_p && (phase_r == 4'hF);
        tick_p = (tick_cnt_r == 27'(TICK_CYC - 1));
        tfault = hotcold_s && !gnd_s;
    end

    // Time base: sub-steps, carrier phase, blink halves and a 1 s tick
    always_comb begin
        step_cnt_nxt = step_p ? 8'h00 : step_cnt_r + 8'h01;
        phase_nxt = step_p ? phase_r + 4'h1 : phase_r;
        half_cnt_nxt = half_cnt_r;
        blink_hi_nxt = blink_hi_r;
        if (carrier_p) begin
            // Magnitude compare: switching to the shorter blink target
            // must not leave the counter stranded past its end
            if (half_cnt_r >= 14'(tfault ?
                    charger_status_pkg::TEMP_HALF - 1 :
                    charger_status_pkg::BAD_HALF - 1)) begin
                half_cnt_nxt = 14'h0000;
                blink_hi_nxt = !blink_hi_r;
            end else begin
                half_cnt_nxt = half_cnt_r + 14'h0001;
            end
        end
        tick_cnt_nxt = tick_p ? 27'h0 : tick_cnt_r + 27'h1;
    end

    // Charger sequence with trickle and safety timers
    always_comb begin
        st_nxt = st_r;
        low_sec_nxt = low_sec_r;
        safe_sec_nxt = safe_sec_r;
        safe_run_nxt = safe_run_r;
        if (start_s) begin
            st_nxt = charger_status_pkg::ST_CHARGE;
            low_sec_nxt = 14'h0000;
            safe_sec_nxt = 14'h0000;
            safe_run_nxt = 1'b0;
        end else begin
            case (st_r)
                charger_status_pkg::ST_CHARGE: begin
                    if (!low_s) begin
                        low_sec_nxt = 14'h0000;
                    end else if (tick_p && !tfault) begin
                        low_sec_nxt = low_sec_r + 14'h0001;
                    end
                    if (low_s && low_sec_r ==
                        14'(charger_status_pkg::TRICKLE_TIMEOUT_S)) begin
                        st_nxt = charger_status_pkg::ST_BAD;
                    end
                    if (float_s) begin
                        safe_run_nxt = 1'b1;
                    end
                    if (safe_run_r && tick_p && !tfault) begin
                        safe_sec_nxt = safe_sec_r + 14'h0001;
                    end
                    if (safe_sec_r ==
                        14'(charger_status_pkg::SAFETY_TIMEOUT_S)) begin
                        st_nxt = charger_status_pkg::ST_DONE;
                    end else if (float_s && tenth_s && !limit_s) begin
                        st_nxt = charger_status_pkg::ST_DONE;
                    end
                end
                charger_status_pkg::ST_IDLE: st_nxt = st_r;
                charger_status_pkg::ST_DONE: st_nxt = st_r;
                charger_status_pkg::ST_BAD: st_nxt = st_r;
                default: st_nxt = charger_status_pkg::ST_IDLE;
            endcase
        end
    end

    // Status encoding; the pin only ever sinks, never sources
    always_comb begin
        duty = 5'h00;
        pull_nxt = 1'b0;
        tf_nxt = 1'b0;
        en_nxt = (st_r == charger_status_pkg::ST_CHARGE) && !tfault;
        if (st_r == charger_status_pkg::ST_BAD) begin
            duty = blink_hi_r ? charger_status_pkg::BAD_HI :
                                charger_status_pkg::BAD_LO;
            pull_nxt = ({1'b0, phase_r} < duty);
        end else if (st_r == charger_status_pkg::ST_CHARGE && tfault) begin
            duty = blink_hi_r ? charger_status_pkg::TEMP_HI :
                                charger_status_pkg::TEMP_LO;
            pull_nxt = ({1'b0, phase_r} < duty);
            tf_nxt = 1'b1;
        end else if (st_r == charger_status_pkg::ST_CHARGE) begin
            pull_nxt = 1'b1;
        end
    end

    // Register all state and outputs
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_r <= charger_status_pkg::ST_IDLE;
            step_cnt_r <= 8'h00;
            phase_r <= 4'h0;
            half_cnt_r <= 14'h0000;
            blink_hi_r <= 1'b0;
            tick_cnt_r <= 27'h0;
            low_sec_r <= 14'h0000;
            safe_sec_r <= 14'h0000;
            safe_run_r <= 1'b0;
            pull_r <= 1'b0;
            en_r <= 1'b0;
            tf_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            step_cnt_r <= step_cnt_nxt;
            phase_r <= phase_nxt;
            half_cnt_r <= half_cnt_nxt;
            blink_hi_r <= blink_hi_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            low_sec_r <= low_sec_nxt;
            safe_sec_r <= safe_sec_nxt;
            safe_run_r <= safe_run_nxt;
            pull_r <= pull_nxt;
            en_r <= en_nxt;
            tf_r <= tf_nxt;
        end
    end

    assign charge_status_out_o = 1'b0;
    assign charge_status_out_oe = pull_r;
    assign charge_enable = en_r;
    assign temp_fault = tf_r;

    sequence s_done;
        st_r == charger_status_pkg::ST_DONE;
    endsequence
    property p_release_done;
        @(posedge clk_sys) disable iff (!resetn)
        s_done |=> !charge_status_out_oe;
    endproperty
    a_release_done: assert property (p_release_done)
        else $error("pin pulled after charge done");
    property p_hold_low;
        @(posedge clk_sys) disable iff (!resetn)
        (st_r == charger_status_pkg::ST_CHARGE && !tfault)
            |=> charge_status_out_oe;
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("pin not low while charging");
    property p_limit_block;
        @(posedge clk_sys) disable iff (!resetn)
        (st_r == charger_status_pkg::ST_CHARGE && limit_s && !start_s &&
         safe_sec_r != 14'(charger_status_pkg::SAFETY_TIMEOUT_S) &&
         !(low_s && low_sec_r ==
           14'(charger_status_pkg::TRICKLE_TIMEOUT_S)))
            |=> st_r == charger_status_pkg::ST_CHARGE;
    endproperty
    a_limit_block: assert property (p_limit_block)
        else $error("end of charge while in current limit");
    property p_drive_low;
        @(posedge clk_sys) disable iff (!resetn)
        charge_status_out_o == 1'b0;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("status pin driven high");
    property p_no_tf_gnd;
        @(posedge clk_sys) disable iff (!resetn)
        $past(gnd_s) |-> !temp_fault;
    endproperty
    a_no_tf_gnd: assert property (p_no_tf_gnd)
        else $error("temp fault with grounded sense");
    property p_pause;
        @(posedge clk_sys) disable iff (!resetn)
        tfault |=> !charge_enable;
    endproperty
    a_pause: assert property (p_pause)
        else $error("charging during temperature fault");
    property p_freeze;
        @(posedge clk_sys) disable iff (!resetn)
        (tfault && !start_s) |=> $stable(safe_sec_r);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("safety timer ran during temp fault");
    property p_bad_duty;
        @(posedge clk_sys) disable iff (!resetn)
        (st_r == charger_status_pkg::ST_BAD && phase_r == 4'h0 && !start_s)
            |=> charge_status_out_oe;
    endproperty
    a_bad_duty: assert property (p_bad_duty)
        else $error("bad battery carrier missing low phase");
    property p_temp_duty;
        @(posedge clk_sys) disable iff (!resetn)
        (st_r == charger_status_pkg::ST_CHARGE && tfault && phase_r == 4'h0)
            |=> charge_status_out_oe;
    endproperty
    a_temp_duty: assert property (p_temp_duty)
        else $error("temp fault carrier missing low phase");
    property p_carrier_gap;
        @(posedge clk_sys) disable iff (!resetn)
        (phase_r == 4'hF && (st_r == charger_status_pkg::ST_BAD || tfault))
            |=> !charge_status_out_oe;
    endproperty
    a_carrier_gap: assert property (p_carrier_gap)
        else $error("fault carrier never releases the pin");
    property p_step;
        @(posedge clk_sys) disable iff (!resetn)
        step_p |=> step_cnt_r == 8'h00;
    endproperty
    a_step: assert property (p_step)
        else $error("step counter did not wrap");
endmodule : charger_status_signalling

// *** tb/status_decoder.sv ***
// Host-side duty decoder on the open-drain status line.
// Assumes the line is pulled up and sampled on the system clock.
`timescale 1ns/10ps
module status_decoder #(
    parameter int WIN = 16 * charger_status_pkg::STEP_CYC
) (
    input wire logic clk_sys, // Sampling clock
    input wire logic pin, // Resolved status line
    output int duty, // Low time in sixteenths
    output logic duty_ok // Reading accepted
);
    int cnt_r = 0;
    int low_r = 0;
    int sum;
    assign sum = low_r + (pin ? 0 : 1);
    // One carrier window per reading; a half-duty reading is thrown away
    always @(posedge clk_sys) begin
        cnt_r <= (cnt_r == WIN - 1) ? 0 : cnt_r + 1;
        low_r <= (cnt_r == WIN - 1) ? 0 : sum;
        if (cnt_r == WIN - 1) begin
            duty <= (sum * 16 + WIN / 2) / WIN;
            duty_ok <= ((sum * 16 + WIN / 2) / WIN) != 8;
        end
    end
endmodule : status_decoder

// *** tb/tb_top.sv ***
// Self-checking bench for the charger status block.
// Assumes a shortened 2-cycle tick so the long timers fit in the run.
`timescale 1ns/10ps
module tb_top;
    localparam int TICK = 2;
    localparam int WIN = 16 * charger_status_pkg::STEP_CYC;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic start = 1'b0, trk = 1'b0, flt = 1'b0, tenth = 1'b0, lim = 1'b0;
    logic hot = 1'b0, cold = 1'b0, gnd = 1'b0;
    logic pin_o, pin_oe, chg_en, tfault, duty_ok;
    logic [31:0] lfsr = 32'hA28A38F0;
    wire logic pin_line;
    int duty, errors = 0, checks = 0, n, run_cyc = 0;
    realtime t0;
    // Pull-up wins unless the block pulls low
    assign pin_line = pin_oe ? pin_o : 1'b1;
    always #5 clk_sys = ~clk_sys;
    // Cycles since reset release; the carrier phase model runs off it
    always @(posedge clk_sys) begin
        if (resetn) begin
            run_cyc <= run_cyc + 1;
        end
    end
    charger_status_signalling #(.TICK_CYC(TICK)) i_charger_status_signalling (
        .clk_sys(clk_sys), .resetn(resetn), .charge_start_in(start),
        .below_trickle_in(trk), .at_float_in(flt), .tenth_current_in(tenth),
        .input_limit_in(lim), .thermistor_hot_in(hot),
        .thermistor_cold_in(cold), .thermistor_grounded_in(gnd),
        .charge_status_out_i(pin_line), .charge_status_out_o(pin_o),
        .charge_status_out_oe(pin_oe), .charge_enable(chg_en),
        .temp_fault(tfault));
    status_decoder i_status_decoder (.clk_sys(clk_sys), .pin(pin_line),
        .duty(duty), .duty_ok(duty_ok));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic report_and_stop;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic chk(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_in(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            errors++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, lo);
        end
    endtask : chk_in
    // Model: mode 0 idle, 1 charging, 2 done; pause means temp fault
    // A paused charge shows the slow blink's low duty, first sixteenth
    task automatic state_is(input int mode, input bit pause);
        int ph;
        ph = ((run_cyc - 1) / charger_status_pkg::STEP_CYC) % 16;
        chk(pin_oe, (mode == 1 && !pause) ||
            (pause && ph < charger_status_pkg::TEMP_LO));
        chk(chg_en, mode == 1 && !pause);
        chk(tfault, pause);
        chk(pin_o, 1'b0);
    endtask : state_is
    task automatic duty_is(input int lo, input int hi);
        cyc(2 * WIN + 2);
        chk(duty_ok, 1'b1);
        checks++;
        if (duty != lo && duty != hi) begin
            errors++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, duty, lo);
        end
    endtask : duty_is
    task automatic pulse_start;
        @(posedge clk_sys) start <= 1'b1;
        @(posedge clk_sys) start <= 1'b0;
        cyc(5);
    endtask : pulse_start
    task automatic wait_drop(input int limit);
        n = 0;
        while (chg_en !== 1'b0 && n < limit) begin
            cyc(1);
            n++;
        end
        if (n >= limit) begin
            errors++;
            report_and_stop;
        end
    endtask : wait_drop
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        cyc(3);
        state_is(0, 0);
        $display("test reset done");
        pulse_start;
        state_is(1, 0);
        chk(pin_line, 1'b0);
        @(posedge clk_sys) {flt, tenth, lim} <= 3'h7;
        cyc(20);
        state_is(1, 0);
        @(posedge clk_sys) lim <= 1'b0;
        cyc(6);
        state_is(2, 0);
        chk(pin_line, 1'b1);
        $display("test end of charge done");
        @(posedge clk_sys) {flt, tenth} <= 2'h0;
        pulse_start;
        lfsr = lfsr_next(lfsr);
        @(posedge clk_sys) {hot, cold} <= {lfsr[0], ~lfsr[0]};
        cyc(6);
        state_is(1, 1);
        duty_is(1, 15);
        @(posedge clk_sys) {hot, cold, gnd} <= 3'h5;
        cyc(20);
        state_is(1, 0);
        @(posedge clk_sys) {hot, gnd} <= 2'h0;
        $display("test temperature done");
        pulse_start;
        @(posedge clk_sys) flt <= 1'b1;
        t0 = $realtime;
        cyc(100);
        @(posedge clk_sys) hot <= 1'b1;
        cyc(1000);
        state_is(1, 1);
        @(posedge clk_sys) hot <= 1'b0;
        cyc(6);
        state_is(1, 0);
        wait_drop(40000);
        chk_in(int'(($realtime - t0) / 10), 29790, 29840);
        cyc(2);
        state_is(2, 0);
        $display("test safety timer done");
        @(posedge clk_sys) {flt, trk} <= 2'h1;
        t0 = $realtime;
        pulse_start;
        wait_drop(5000);
        chk_in(int'(($realtime - t0) / 10), 3595, 3625);
        duty_is(2, 14);
        @(posedge clk_sys) trk <= 1'b0;
        pulse_start;
        state_is(1, 0);
        $display("test bad battery done");
        report_and_stop;
    end
endmodule : tb_top
